/* File: inc/tcc_params.svh */
// Register map, field positions and reset values of the channel 4 I/O control timer block.
// Assumes a 32-bit classic Wishbone slave with one register per aligned word.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

`define TCC_IDX_IO_HIGH 4'h0
`define TCC_IDX_IO_LOW 4'h1
`define TCC_IDX_MODE 4'h2
`define TCC_IDX_STATUS 4'h3
`define TCC_IDX_COUNT 4'h4
`define TCC_IDX_GR_A 4'h5
`define TCC_IDX_GR_B 4'h6
`define TCC_IDX_GR_C 4'h7
`define TCC_IDX_GR_D 4'h8
`define TCC_IDX_IER0 4'h9
`define TCC_IDX_IER4 4'hd

`define TCC_MODE_CNT_EN 0
`define TCC_MODE_BUF_A 4
`define TCC_MODE_BUF_B 5
`define TCC_MODE_WMASK 8'h31

`define TCC_ST_OVF 4
`define TCC_ST_FIXED 8'hc0

`define TCC_IER_RESET 8'h40
`define TCC_IER_ADC 7
`define TCC_IER_WMASK_CH0 8'h9f
`define TCC_IER_WMASK_CH12 8'hb3
`define TCC_IER_WMASK_CH34 8'h9f

`define TCC_FLD_CAP 3
`define TCC_FLD_INIT 2

`endif

/* File: inc/tcc_pkg.sv */
// Types shared by the channel 4 I/O control timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_F_OFF = 2'b00,
    TCC_F_CMP = 2'b01,
    TCC_F_CAP = 2'b10
  } tcc_func_e;

  typedef struct packed {
    logic out;
    logic oe;
  } tcc_pin_s;

  typedef logic [3:0] tcc_field_t;

endpackage

/* File: rtl/tcc_top.sv */
// Channel 4 I/O control, compare and capture logic plus the five interrupt enable registers.
// Assumes a classic Wishbone master, pin inputs synchronous to sys_clk, flags of channels 0-3
// supplied by their own logic.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"

// Behaviour
// - Zero field keeps the pin output disabled.
// - Codes 0001/0101 drive pin low on match.
// - Codes 0010/0110 drive pin high on match.
// - Codes 0011/0111 toggle pin on match.
// - Field bit 2 sets initial level; 0100 disables.
// - Bit3 with low bits 00 captures rising edges.
// - Bit3 with low bits 01 captures falling edges.
// - Bit3 with bit1 captures both edges.
// - Each register captures from its own pin.
// - Buffer B mode disables register D function.
// - Buffer A mode disables register C function.
// - High register holds B then A fields.
// - Low register holds D then C fields.
// - Eight-bit enable registers gate channel requests.
// - Enable registers reset to 40 on standby.
// - Five channels each own an enable register.
// - Bit 7 gates conversion start on A events.
// - Bit 4 gates the overflow request.
// - Bits 3-0 gate the D-A flag requests.
// - Bit 5 gates underflow on channels 1, 2.
module tcc_top
  import tcc_pkg::*;
#(
  parameter int DIV = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic standby,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] timer_pin_in,
  output logic [3:0] timer_pin_out,
  output logic [3:0] timer_pin_oe,
  input wire logic [3:0][5:0] chan_flags,
  input wire logic [3:0] chan_a_event,
  output logic [4:0][5:0] irq_req,
  output logic [4:0] adc_start
);

  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [7:0] io_high_r, io_high_nxt;
  logic [7:0] io_low_r, io_low_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [4:0] flag_r, flag_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0][15:0] gr_r, gr_nxt;
  logic [4:0][7:0] ier_r, ier_nxt;
  logic [15:0] div_r, div_nxt;
  logic [3:0] pin_prev_r;
  tcc_pin_s [3:0] pin_r, pin_nxt;
  logic [4:0][5:0] irq_nxt;
  logic [4:0] adc_nxt;

  logic acc, wr, hit;
  logic [3:0] idx;
  logic tick;
  tcc_field_t [3:0] fld, eff;
  logic [3:0] match, capt, io_wr;
  logic [15:0] io_all_nxt;
  logic [4:0][5:0] flags_all;
  logic [4:0] a_event;

  // Decodes a function field into off, compare or capture.
  function automatic tcc_func_e fld_func(input tcc_field_t f);
    if (f[`TCC_FLD_CAP]) begin
      fld_func = TCC_F_CAP;
    end else if (f[1:0] != 2'h0) begin
      fld_func = TCC_F_CMP;
    end else begin
      fld_func = TCC_F_OFF;
    end
  endfunction

  // True when the pin edge matches the capture edge the field selects.
  function automatic logic cap_edge(input tcc_field_t f, input logic now, input logic prev);
    if (f[1]) begin
      cap_edge = now ^ prev;
    end else if (f[0]) begin
      cap_edge = prev & ~now;
    end else begin
      cap_edge = now & ~prev;
    end
  endfunction

  // Merges the enabled byte lanes of write data into a 16-bit register.
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    lane16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // Enable register write mask per channel; reserved bits never change.
  function automatic logic [7:0] ier_wmask(input int ch);
    if (ch == 0) begin
      ier_wmask = `TCC_IER_WMASK_CH0;
    end else if (ch <= 2) begin
      ier_wmask = `TCC_IER_WMASK_CH12;
    end else begin
      ier_wmask = `TCC_IER_WMASK_CH34;
    end
  endfunction

  assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = acc & wb_we_i;
  assign idx = wb_adr_i[5:2];
  assign hit = (wb_adr_i[7:6] == 2'h0) && (idx <= `TCC_IDX_IER4);
  assign tick = mode_r[`TCC_MODE_CNT_EN] && (div_r == 16'h0000);
  assign io_all_nxt = {io_low_nxt, io_high_nxt};

  always_comb begin
    fld[0] = io_high_r[3:0];
    fld[1] = io_high_r[7:4];
    fld[2] = io_low_r[3:0];
    fld[3] = io_low_r[7:4];
    eff = fld;
    // A register serving as a buffer has no pin function at all.
    if (mode_r[`TCC_MODE_BUF_A]) begin
      eff[2] = 4'h0;
    end
    if (mode_r[`TCC_MODE_BUF_B]) begin
      eff[3] = 4'h0;
    end
    for (int i = 0; i < 4; i++) begin
      match[i] = tick && (fld_func(eff[i]) == TCC_F_CMP) && (cnt_r == gr_r[i]);
      capt[i] = (fld_func(eff[i]) == TCC_F_CAP) &&
                cap_edge(eff[i], timer_pin_in[i], pin_prev_r[i]);
    end
  end

  always_comb begin
    ack_nxt = acc;
    rdat_nxt = 32'h0000_0000;
    io_high_nxt = io_high_r;
    io_low_nxt = io_low_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    gr_nxt = gr_r;
    ier_nxt = ier_r;
    flag_nxt = flag_r;
    io_wr = 4'h0;
    div_nxt = div_r;
    if (mode_r[`TCC_MODE_CNT_EN]) begin
      div_nxt = (div_r >= 16'(DIV - 1)) ? 16'h0000 : div_r + 16'h0001;
    end
    if (tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (acc && hit && !wb_we_i) begin
      case (idx)
        `TCC_IDX_IO_HIGH: rdat_nxt = {24'h0, io_high_r};
        `TCC_IDX_IO_LOW: rdat_nxt = {24'h0, io_low_r};
        `TCC_IDX_MODE: rdat_nxt = {24'h0, mode_r};
        `TCC_IDX_STATUS: rdat_nxt = {24'h0, `TCC_ST_FIXED | {3'h0, flag_r}};
        `TCC_IDX_COUNT: rdat_nxt = {16'h0, cnt_r};
        `TCC_IDX_GR_A, `TCC_IDX_GR_B, `TCC_IDX_GR_C, `TCC_IDX_GR_D: begin
          rdat_nxt = {16'h0, gr_r[2'(idx - `TCC_IDX_GR_A)]};
        end
        default: rdat_nxt = {24'h0, ier_r[3'(idx - `TCC_IDX_IER0)]};
      endcase
    end
    if (wr && hit && wb_sel_i[0]) begin
      case (idx)
        `TCC_IDX_IO_HIGH: begin
          io_high_nxt = wb_dat_i[7:0];
          io_wr[1:0] = 2'h3;
        end
        `TCC_IDX_IO_LOW: begin
          io_low_nxt = wb_dat_i[7:0];
          io_wr[3:2] = 2'h3;
        end
        `TCC_IDX_MODE: mode_nxt = wb_dat_i[7:0] & `TCC_MODE_WMASK;
        // A flag clears only where a zero is written.
        `TCC_IDX_STATUS: flag_nxt = flag_r & wb_dat_i[4:0];
        default: ;
      endcase
    end
    if (wr && hit && (wb_sel_i[1:0] != 2'h0)) begin
      case (idx)
        `TCC_IDX_COUNT: cnt_nxt = lane16(cnt_r, wb_dat_i, wb_sel_i);
        `TCC_IDX_GR_A, `TCC_IDX_GR_B, `TCC_IDX_GR_C, `TCC_IDX_GR_D: begin
          gr_nxt[2'(idx - `TCC_IDX_GR_A)] = lane16(gr_r[2'(idx - `TCC_IDX_GR_A)],
                                                    wb_dat_i, wb_sel_i);
        end
        default: ;
      endcase
    end
    for (int c = 0; c < 5; c++) begin
      if (wr && hit && wb_sel_i[0] && (idx == 4'(`TCC_IDX_IER0 + c))) begin
        ier_nxt[c] = (wb_dat_i[7:0] & ier_wmask(c)) | `TCC_IER_RESET;
      end
      if (standby) begin
        ier_nxt[c] = `TCC_IER_RESET;
      end
    end
    // A capture wins over a software write to the same general register.
    for (int i = 0; i < 4; i++) begin
      if (capt[i]) begin
        gr_nxt[i] = cnt_r;
      end
    end
    // Hardware events win over a clearing write in the same cycle.
    flag_nxt = flag_nxt | {tick && (cnt_r == 16'hffff), match | capt};
  end

  always_comb begin
    pin_nxt = pin_r;
    for (int i = 0; i < 4; i++) begin
      pin_nxt[i].oe = (fld_func(eff[i]) == TCC_F_CMP);
      if (io_wr[i]) begin
        // The initial level comes from the field being written, not the one it replaces.
        pin_nxt[i].out = io_all_nxt[4 * i + `TCC_FLD_INIT];
      end else if (match[i]) begin
        case (eff[i][1:0])
          2'h1: pin_nxt[i].out = 1'b0;
          2'h2: pin_nxt[i].out = 1'b1;
          2'h3: pin_nxt[i].out = ~pin_r[i].out;
          default: pin_nxt[i].out = pin_r[i].out;
        endcase
      end
    end
  end

  always_comb begin
    flags_all[3:0] = chan_flags;
    flags_all[4] = {1'b0, flag_r};
    a_event[3:0] = chan_a_event;
    a_event[4] = match[0] | capt[0];
    for (int c = 0; c < 5; c++) begin
      irq_nxt[c] = flags_all[c] & ier_r[c][5:0];
      adc_nxt[c] = a_event[c] & ier_r[c][`TCC_IER_ADC];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      io_high_r <= 8'h00;
      io_low_r <= 8'h00;
      mode_r <= 8'h00;
      flag_r <= 5'h00;
      cnt_r <= 16'h0000;
      gr_r <= '0;
      ier_r <= {5{`TCC_IER_RESET}};
      div_r <= 16'h0000;
      pin_prev_r <= 4'h0;
      pin_r <= '0;
      irq_req <= '0;
      adc_start <= 5'h00;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      io_high_r <= io_high_nxt;
      io_low_r <= io_low_nxt;
      mode_r <= mode_nxt;
      flag_r <= flag_nxt;
      cnt_r <= cnt_nxt;
      gr_r <= gr_nxt;
      ier_r <= ier_nxt;
      div_r <= div_nxt;
      pin_prev_r <= timer_pin_in;
      pin_r <= pin_nxt;
      irq_req <= irq_nxt;
      adc_start <= adc_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      timer_pin_out[i] = pin_r[i].out;
      timer_pin_oe[i] = pin_r[i].oe;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // Pin checks look one edge after the decision, since the pin stage is registered.
  a_off_no_drive: assert property ((fld[0] == 4'h0) |=> !timer_pin_oe[0])
    else $error("pin A driven while its field is zero");
  a_off_no_drive_c: assert property ((fld[2] == 4'h0) |=> !timer_pin_oe[2])
    else $error("pin C driven while its field is zero");
  a_match_low: assert property (
      (match[0] && eff[0][1:0] == 2'h1 && !io_wr[0]) |=> !timer_pin_out[0])
    else $error("pin A not low after match");
  a_match_high: assert property (
      (match[0] && eff[0][1:0] == 2'h2 && !io_wr[0]) |=> timer_pin_out[0])
    else $error("pin A not high after match");
  a_match_toggle: assert property (
      (match[0] && eff[0][1:0] == 2'h3 && !io_wr[0])
      |=> timer_pin_out[0] != $past(timer_pin_out[0]))
    else $error("pin A did not toggle on match");
  a_init_level: assert property (
      (wr && hit && idx == `TCC_IDX_IO_HIGH && wb_sel_i[0])
      |=> timer_pin_out[0] == $past(wb_dat_i[`TCC_FLD_INIT]))
    else $error("pin A initial level wrong");
  a_disable_code: assert property ((fld[1] == 4'h4) |=> !timer_pin_oe[1])
    else $error("pin B driven while its field disables it");
  a_rise_capture: assert property (
      (fld_func(eff[0]) == TCC_F_CAP && eff[0][1:0] == 2'h0 &&
       timer_pin_in[0] && !pin_prev_r[0]) |-> capt[0])
    else $error("rising edge missed");
  a_rise_only: assert property (
      (capt[0] && eff[0][1:0] == 2'h0) |-> timer_pin_in[0] && !pin_prev_r[0])
    else $error("rising capture on wrong edge");
  a_fall_capture: assert property (
      (capt[2] && eff[2][1:0] == 2'h1) |-> !timer_pin_in[2] && pin_prev_r[2])
    else $error("falling capture on wrong edge");
  a_both_capture: assert property (
      (fld_func(eff[3]) == TCC_F_CAP && eff[3][1] && timer_pin_in[3] != pin_prev_r[3])
      |-> capt[3])
    else $error("pin D edge missed in both-edge mode");
  a_own_pin: assert property (capt[1] |-> timer_pin_in[1] != pin_prev_r[1])
    else $error("register B captured without an edge on its pin");
  a_capture_copy: assert property (capt[1] |=> gr_r[1] == $past(cnt_r))
    else $error("capture did not copy the counter");
  a_buffer_d: assert property (
      mode_r[`TCC_MODE_BUF_B] |-> !capt[3] && !match[3] ##1 !timer_pin_oe[3])
    else $error("register D active in buffer mode");
  a_buffer_c: assert property (
      mode_r[`TCC_MODE_BUF_A] |-> !capt[2] && !match[2] ##1 !timer_pin_oe[2])
    else $error("register C active in buffer mode");
  a_field_high: assert property (
      (wr && hit && idx == `TCC_IDX_IO_HIGH && wb_sel_i[0])
      |=> fld[1] == $past(wb_dat_i[7:4]) && fld[0] == $past(wb_dat_i[3:0]))
    else $error("high control register fields misplaced");
  a_field_low: assert property (
      (wr && hit && idx == `TCC_IDX_IO_LOW && wb_sel_i[0])
      |=> fld[3] == $past(wb_dat_i[7:4]) && fld[2] == $past(wb_dat_i[3:0]))
    else $error("low control register fields misplaced");
  a_ier_fixed: assert property (
      ier_r[0][6] && ier_r[1][6] && ier_r[2][6] && ier_r[3][6] && ier_r[4][6] &&
      !ier_r[1][3] && !ier_r[2][2])
    else $error("reserved enable bit changed");
  a_ier_standby: assert property (standby |=> ier_r[2] == `TCC_IER_RESET)
    else $error("enable register not reset by standby");
  a_ier_read: assert property (
      (acc && hit && !wb_we_i && idx == (`TCC_IDX_IER0 + 4'h2))
      |=> wb_dat_o[7:0] == $past(ier_r[2]))
    else $error("channel 2 enable register read wrong");
  a_adc_gate: assert property (
      (match[0] && ier_r[4][`TCC_IER_ADC]) |=> adc_start[4])
    else $error("conversion start missing");
  a_adc_block: assert property (!ier_r[4][`TCC_IER_ADC] |=> !adc_start[4])
    else $error("conversion start passed a cleared enable");
  a_ovf_gate: assert property ((flags_all[1][4] && ier_r[1][4]) |=> irq_req[1][4])
    else $error("overflow request missing");
  a_irq_gate: assert property ((!ier_r[4][0]) |=> !irq_req[4][0])
    else $error("match A request passed a cleared enable");
  a_irq_gate_b: assert property ((!ier_r[0][1]) |=> !irq_req[0][1])
    else $error("match B request passed a cleared enable");
  a_under_gate: assert property ((flags_all[2][5] && ier_r[2][5]) |=> irq_req[2][5])
    else $error("underflow request missing");
  a_match_flag: assert property (
      (tick && fld_func(eff[0]) == TCC_F_CMP && cnt_r == gr_r[0]) |=> flag_r[0])
    else $error("compare match not flagged");

  c_toggle: cover property (match[0] && eff[0][1:0] == 2'h3);
  c_both_edges: cover property (capt[3] && eff[3][1]);
  c_overflow: cover property (tick && cnt_r == 16'hffff);
  c_adc: cover property (adc_start[4]);
  c_buffer_c: cover property (mode_r[`TCC_MODE_BUF_A] && fld_func(fld[2]) == TCC_F_CMP);

endmodule
`default_nettype wire

/* File: tb/tcc_pin_model.sv */
// Outside circuitry on the four timer pins of channel 4.
// Assumes the bench sets the wanted outside levels just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] ext_level,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in
);
  logic [3:0] level_r;
  logic [3:0] level_nxt;
  always_comb begin
    level_nxt = ext_level;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_r <= 4'h0;
    end else begin
      level_r <= level_nxt;
    end
  end
  // A driven pin reads back the device level, so a capture never sees the outside source then.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & level_r);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the channel 4 I/O control timer block.
// Assumes the register map of the block and its one-cycle Wishbone answer.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk = 1'b0, resetn = 1'b0, standby = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic ack;
  logic [3:0] pin_in, pin_out, pin_oe, ext = 4'h0, ev = 4'h0;
  logic [3:0][5:0] flags = 24'h0;
  logic [4:0][5:0] irq;
  logic [4:0] adc;
  logic [3:0] code;
  logic [31:0] v;
  int bad_count = 0, checks_done = 0, cycles = 0, i, c, e;
  int ier_m[5];
  int wmask[5] = '{32'h9f, 32'hb3, 32'hb3, 32'h9f, 32'h9f};

  tcc_top #(.DIV(1)) i_tcc_top (.sys_clk(sys_clk), .resetn(resetn), .standby(standby),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .timer_pin_in(pin_in),
    .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .chan_flags(flags),
    .chan_a_event(ev), .irq_req(irq), .adc_start(adc));
  tcc_pin_model i_tcc_pin_model (.sys_clk(sys_clk), .resetn(resetn), .ext_level(ext),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  initial forever #2 sys_clk = ~sys_clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The ceiling is more than ten times the length of the whole sequence.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle: request held until ack is sampled high at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Capture on register ri: other pins flip first, then its own pin makes the chosen edge.
  task automatic cap_case(input int ri, input logic [3:0] cd, input int fall, input int m);
    logic [31:0] kk;
    logic hit;
    kk = 32'($urandom) & 32'h0000ffff;
    wr(8'h08, 32'(m));
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    ext <= fall ? 4'hf : 4'h0;
    wr(8'(32'h14 + 4 * ri), 32'h0);
    wr(8'h10, kk);
    wr((ri < 2) ? 8'h00 : 8'h04, 32'(cd) << (4 * (ri % 2)));
    ext <= ext ^ ~(4'h1 << ri);
    settle(6);
    rd(8'(32'h14 + 4 * ri), 32'h0);
    ext <= ext ^ (4'h1 << ri);
    settle(6);
    hit = (cd[1] | (fall ? cd[0] : ~cd[0])) && !(m[4] && ri == 2) && !(m[5] && ri == 3);
    rd(8'(32'h14 + 4 * ri), hit ? kk : 32'h0);
  endtask

  initial begin
    void'($urandom(32'h9264));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++) ier_m[i] = 32'h40;
    for (i = 0; i < 5; i++) rd(8'(32'h24 + 4 * i), 32'h40);
    rd(8'h00, 32'h0);
    chk(pin_oe, 4'h0);
    for (i = 0; i < 5; i++) begin
      v = $urandom;
      wr(8'(32'h24 + 4 * i), v);
      ier_m[i] = (v & wmask[i]) | 32'h40;
      rd(8'(32'h24 + 4 * i), ier_m[i]);
    end
    @(posedge sys_clk);
    flags <= 24'($urandom);
    ev <= 4'hf;
    @(posedge sys_clk);
    ev <= 4'h0;
    #1;
    for (i = 0; i < 4; i++) chk(adc[i], ier_m[i][7]);
    settle(1);
    for (i = 0; i < 4; i++) chk(irq[i], flags[i] & ier_m[i][5:0]);
    chk(irq[4], 6'h0);
    @(posedge sys_clk);
    standby <= 1'b1;
    repeat (2) @(posedge sys_clk);
    standby <= 1'b0;
    for (i = 0; i < 5; i++) rd(8'(32'h24 + 4 * i), 32'h40);
    wr(8'h34, 32'h80);
    rd(8'h34, 32'hc0);
    wr(8'h14, 32'h5);
    for (c = 1; c < 8; c++) begin
      code = 4'(c);
      wr(8'h08, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h00, 32'(code));
      settle(2);
      chk({pin_oe, pin_out[0] & pin_oe[0]}, {3'h0, c != 4, code[2] & (c != 4)});
      wr(8'h08, 32'h1);
      settle(20);
      e = (code[1:0] == 2'b01) ? 0 : (code[1:0] == 2'b10) ? 1 : int'(!code[2]);
      chk({pin_oe[0], pin_out[0] & pin_oe[0]}, {c != 4, e[0] & (c != 4)});
    end
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h10);
    wr(8'h04, 32'h22);
    settle(2);
    chk(pin_oe, 4'b1000);
    wr(8'h08, 32'h20);
    settle(2);
    chk(pin_oe, 4'b0100);
    for (i = 0; i < 4; i++) begin
      foreach (wmask[c]) if (c < 4) cap_case(i, 4'h8 | 4'(c + c / 2), c % 2, 0);
      cap_case(i, 4'hd, 1, 0);
      cap_case(i, 4'hb, 0, 0);
      cap_case(i, 4'h8, 0, 32'h30);
    end
    finish_test();
  end
endmodule
`default_nettype wire
